// [src/sys_timers_pkg.sv]
// constants of the reload/capture timer and the two simple timers
// assumes an apb master on the system clock with 32-bit data
package sys_timers_pkg;
   localparam logic [7:0]  ADDR_RT_CTRL  = 8'hC8;
   localparam logic [7:0]  ADDR_RC_LOW   = 8'hCA;
   localparam logic [7:0]  ADDR_RC_HIGH  = 8'hCB;
   localparam logic [7:0]  ADDR_RT_LOW   = 8'hCC;
   localparam logic [7:0]  ADDR_RT_HIGH  = 8'hCD;
   localparam logic [7:0]  ADDR_ST_CTRL  = 8'hCF;
   localparam logic [7:0]  ADDR_S1_LOW   = 8'hAE;
   localparam logic [7:0]  ADDR_S1_HIGH  = 8'hAF;
   localparam logic [7:0]  ADDR_S2_LOW   = 8'hAC;
   localparam logic [7:0]  ADDR_S2_HIGH  = 8'hAD;
   // reload timer control bit positions
   localparam int RT_OVF   = 7;
   localparam int RT_EXF   = 6;
   localparam int RT_RXB   = 5;
   localparam int RT_TXB   = 4;
   localparam int RT_EXEN  = 3;
   localparam int RT_RUN   = 2;
   localparam int RT_CT    = 1;
   localparam int RT_CPRL  = 0;
   // simple timers control bit positions
   localparam int S2_OVF   = 7;
   localparam int S2_MODE  = 6;
   localparam int S2_RUN   = 5;
   localparam int S2_IEN   = 4;
   localparam int S1_OVF   = 3;
   localparam int S1_MODE  = 2;
   localparam int S1_RUN   = 1;
   localparam int S1_IEN   = 0;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_ALLONES = 16'hFFFF;
   typedef enum logic [1:0] {
      MODE_STOP    = 2'b00,
      MODE_RELOAD  = 2'b01,
      MODE_CAPTURE = 2'b11,
      MODE_BAUD    = 2'b10
   } rt_mode_t;
endpackage : sys_timers_pkg

// [src/sys_timers.sv]
// reload/capture timer plus two simple 16-bit timers behind an apb slave
// assumes pin inputs synchronous to sys_clk; reset rstn asynchronous
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// one simple timer: live counter, reload register and wrap detect
module simple_timer
   import sys_timers_pkg::*;
#(
   parameter logic [15:0] CNT_INIT = COUNT_RESET  // count after reset
)
(
   input  wire logic        sys_clk,   // system clock
   input  wire logic        rst_n,     // synchronised reset, low active
   input  wire logic        run,       // count while set
   input  wire logic        reload,    // 1 auto-reload, 0 free-run
   input  wire logic        wr_low,    // software writes the low byte
   input  wire logic        wr_high,   // software writes the high byte
   input  wire logic [7:0]  wd,        // byte written
   output logic      [15:0] cnt,       // live count, no snapshot
   output logic             ovf        // wraps from all ones this cycle
);
   logic [15:0] rld;
   logic [15:0] next_cnt;
   logic [15:0] next_rld;

   assign ovf = run & (cnt == COUNT_ALLONES);

   always_comb
   begin
      next_cnt = cnt;
      next_rld = rld;
      if (run)
         next_cnt = (ovf && reload) ? rld
                                    : cnt + 16'h0001;
      // count write: reload register in reload mode, counter otherwise
      if (wr_low)
      begin
         if (reload)
            next_rld[7:0] = wd;
         else
            next_cnt[7:0] = wd;
      end
      if (wr_high)
      begin
         if (reload)
            next_rld[15:8] = wd;
         else
            next_cnt[15:8] = wd;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= CNT_INIT;
         rld <= CNT_INIT;
      end
      else
      begin
         cnt <= next_cnt;
         rld <= next_rld;
      end
   end
endmodule : simple_timer

module sys_timers
   import sys_timers_pkg::*;
(
   input  wire logic        sys_clk,        // system clock
   input  wire logic        rstn,           // async reset, low active
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb access phase
   input  wire logic        pwrite,         // apb direction
   input  wire logic [11:0] paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   output logic      [31:0] prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        ext_pin,        // shared count/trigger pin
   output logic             serial_rx_clk,  // receiver bit clock pulse
   output logic             serial_tx_clk,  // transmitter bit clock pulse
   input  wire logic        other_timer_ovf, // other timer overflow pulse
   output logic             reload_timer_irq, // reload timer request
   output logic             first_simple_irq, // first simple timer request
   output logic             second_simple_irq // second simple timer request
);
   logic rst_s1, rst_s2;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   wire logic rst_n = rst_s2;

   // apb decode: access phase, word address = sfr address * 4
   wire logic       acc  = psel & penable;
   wire logic       wr   = acc & pwrite;
   wire logic [7:0] widx = paddr[9:2];
   wire logic       wok  = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
   wire logic [7:0] wd   = pwdata[7:0];
   function automatic logic hit(input logic [7:0] a, input logic [7:0] i,
                                input logic ok);
      hit = ok && (a == i);
   endfunction : hit

   // state
   logic [7:0]  rt_ctrl, next_rt_ctrl;
   logic [15:0] rt_cnt, next_rt_cnt;
   logic [15:0] rc_reg, next_rc_reg;
   logic [7:0]  st_ctrl, next_st_ctrl;
   logic [15:0] s1_cnt;
   logic [15:0] s2_cnt;
   logic        s1_ovf;
   logic        s2_ovf;
   logic        pin_d, next_pin_d;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        next_rx, next_tx;
   rt_mode_t    mode;

   // one shared pin drives both counting and trigger
   wire logic pin_fall = pin_d & ~ext_pin;
   wire logic baud     = rt_ctrl[RT_RXB] | rt_ctrl[RT_TXB];
   wire logic trig     = rt_ctrl[RT_EXEN] & pin_fall;

   always_comb
   begin
      // mode select
      if (!rt_ctrl[RT_RUN])
         mode = MODE_STOP;
      else if (baud)
         mode = MODE_BAUD;
      else if (rt_ctrl[RT_CPRL])
         mode = MODE_CAPTURE;
      else
         mode = MODE_RELOAD;
   end

   // reload timer tick: system clock or pin falling edge
   wire logic rt_tick = (mode != MODE_STOP) &
                        (rt_ctrl[RT_CT] ? pin_fall : 1'b1);
   wire logic rt_ovf  = rt_tick & (rt_cnt == COUNT_ALLONES);

   always_comb
   begin
      next_pin_d   = ext_pin;
      next_rt_ctrl = rt_ctrl;
      next_rt_cnt  = rt_cnt;
      next_rc_reg  = rc_reg;
      next_rx      = 1'b0;
      next_tx      = 1'b0;
      if (wr && hit(widx, ADDR_RT_CTRL, wok))
         next_rt_ctrl = wd;
      if (wr && hit(widx, ADDR_RT_LOW, wok))
         next_rt_cnt[7:0] = wd;
      if (wr && hit(widx, ADDR_RT_HIGH, wok))
         next_rt_cnt[15:8] = wd;
      if (wr && hit(widx, ADDR_RC_LOW, wok))
         next_rc_reg[7:0] = wd;
      if (wr && hit(widx, ADDR_RC_HIGH, wok))
         next_rc_reg[15:8] = wd;
      if (rt_tick)
         next_rt_cnt = rt_cnt + 16'h0001;
      case (mode)
         MODE_RELOAD:
         begin
            if (rt_ovf)
            begin
               next_rt_ctrl[RT_OVF] = 1'b1;
               next_rt_cnt = rc_reg;
            end
            if (trig)
               next_rt_cnt = rc_reg;
         end
         MODE_CAPTURE:
         begin
            if (rt_ovf)
               next_rt_ctrl[RT_OVF] = 1'b1;
            if (trig)
               next_rc_reg = rt_cnt;
         end
         MODE_BAUD:
         begin
            // flag stays untouched here
            if (rt_ovf)
               next_rt_cnt = rc_reg;
         end
         default:
            next_rt_cnt = next_rt_cnt;
      endcase
      if (trig)
         next_rt_ctrl[RT_EXF] = 1'b1;
      // serial bit clocks from this timer or the other one
      next_rx = rt_ctrl[RT_RXB] ? (rt_ovf & baud)
                                : other_timer_ovf;
      next_tx = rt_ctrl[RT_TXB] ? (rt_ovf & baud)
                                : other_timer_ovf;
   end

   // simple timers: one instance each, control bits in the shared register
   wire logic s1_wr_low  = wr && hit(widx, ADDR_S1_LOW, wok);
   wire logic s1_wr_high = wr && hit(widx, ADDR_S1_HIGH, wok);
   wire logic s2_wr_low  = wr && hit(widx, ADDR_S2_LOW, wok);
   wire logic s2_wr_high = wr && hit(widx, ADDR_S2_HIGH, wok);

   simple_timer #(
      .CNT_INIT (COUNT_RESET)
   ) first_timer (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .run      (st_ctrl[S1_RUN]),
      .reload   (st_ctrl[S1_MODE]),
      .wr_low   (s1_wr_low),
      .wr_high  (s1_wr_high),
      .wd       (wd),
      .cnt      (s1_cnt),
      .ovf      (s1_ovf)
   );

   simple_timer #(
      .CNT_INIT (COUNT_RESET)
   ) second_timer (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .run      (st_ctrl[S2_RUN]),
      .reload   (st_ctrl[S2_MODE]),
      .wr_low   (s2_wr_low),
      .wr_high  (s2_wr_high),
      .wd       (wd),
      .cnt      (s2_cnt),
      .ovf      (s2_ovf)
   );

   always_comb
   begin
      next_st_ctrl = st_ctrl;
      if (wr && hit(widx, ADDR_ST_CTRL, wok))
         next_st_ctrl = wd;
      // set wins over a software clear in the same cycle
      if (s1_ovf)
         next_st_ctrl[S1_OVF] = 1'b1;
      if (s2_ovf)
         next_st_ctrl[S2_OVF] = 1'b1;
   end

   // apb read mux and error on unmapped address
   // read data is taken at setup and stands until the next setup;
   // error and ready stand for the access cycle only
   logic next_pready;

   always_comb
   begin
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      next_pready  = psel & ~penable;
      if (psel && !penable)
      begin
         next_prdata = 32'h0000_0000;
         if (!wok)
            next_pslverr = 1'b1;
         else
            case (widx)
               ADDR_RT_CTRL: next_prdata[7:0] = rt_ctrl;
               ADDR_RC_LOW:  next_prdata[7:0] = rc_reg[7:0];
               ADDR_RC_HIGH: next_prdata[7:0] = rc_reg[15:8];
               ADDR_RT_LOW:  next_prdata[7:0] = rt_cnt[7:0];
               ADDR_RT_HIGH: next_prdata[7:0] = rt_cnt[15:8];
               ADDR_ST_CTRL: next_prdata[7:0] = st_ctrl;
               ADDR_S1_LOW:  next_prdata[7:0] = s1_cnt[7:0];
               ADDR_S1_HIGH: next_prdata[7:0] = s1_cnt[15:8];
               ADDR_S2_LOW:  next_prdata[7:0] = s2_cnt[7:0];
               ADDR_S2_HIGH: next_prdata[7:0] = s2_cnt[15:8];
               default:      next_pslverr = 1'b1;
            endcase
      end
   end

   // requests follow the flags that the same edge stores
   logic next_rt_irq;
   logic next_s1_irq;
   logic next_s2_irq;

   always_comb
   begin
      next_rt_irq = next_rt_ctrl[RT_OVF] | next_rt_ctrl[RT_EXF];
      next_s1_irq = next_st_ctrl[S1_OVF] & next_st_ctrl[S1_IEN];
      next_s2_irq = next_st_ctrl[S2_OVF] & next_st_ctrl[S2_IEN];
   end

   // reload timer; the pin copy idles high so reset makes no false edge
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rt_ctrl <= CTRL_RESET;
         rt_cnt  <= COUNT_RESET;
         rc_reg  <= COUNT_RESET;
         pin_d   <= 1'b1;
      end
      else
      begin
         rt_ctrl <= next_rt_ctrl;
         rt_cnt  <= next_rt_cnt;
         rc_reg  <= next_rc_reg;
         pin_d   <= next_pin_d;
      end
   end

   // shared control and status of the simple timers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ctrl <= CTRL_RESET;
      end
      else
      begin
         st_ctrl <= next_st_ctrl;
      end
   end

   // apb answer
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // serial bit clock pulses
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_rx_clk <= 1'b0;
         serial_tx_clk <= 1'b0;
      end
      else
      begin
         serial_rx_clk <= next_rx;
         serial_tx_clk <= next_tx;
      end
   end

   // interrupt requests
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reload_timer_irq  <= 1'b0;
         first_simple_irq  <= 1'b0;
         second_simple_irq <= 1'b0;
      end
      else
      begin
         reload_timer_irq  <= next_rt_irq;
         first_simple_irq  <= next_s1_irq;
         second_simple_irq <= next_s2_irq;
      end
   end
endmodule : sys_timers
`default_nettype wire

// [dv/sys_timers_assertions.sv]
// checker for the apb port and simple timer requests of sys_timers
// assumes it is bound to sys_timers and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module sys_timers_checker
   import sys_timers_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        first_simple_irq,
   input wire logic        second_simple_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic ctrl_wr;
   assign ctrl_wr = psel && penable && pwrite
                    && paddr == {2'b00, ADDR_ST_CTRL, 2'b00};
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_unmapped_a: assert property (psel && !penable && paddr == 12'h000
      |=> pslverr)
      else $error("unmapped access not refused");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   first_irq_a: assert property (ctrl_wr && pwdata[3] && pwdata[0]
      |-> ##2 first_simple_irq)
      else $error("first request missing");
   first_mask_a: assert property (ctrl_wr && !pwdata[0]
      |-> ##2 !first_simple_irq)
      else $error("first request not masked");
   second_irq_a: assert property (ctrl_wr && pwdata[7] && pwdata[4]
      |-> ##2 second_simple_irq)
      else $error("second request missing");
   second_mask_a: assert property (ctrl_wr && !pwdata[4]
      |-> ##2 !second_simple_irq)
      else $error("second request not masked");
endmodule : sys_timers_checker
bind sys_timers sys_timers_checker chk (.sys_clk, .rstn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .first_simple_irq,
   .second_simple_irq);
`default_nettype wire

// [dv/timer_pins_model.sv]
// shared count/trigger pin and other timer overflow source
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module timer_pins_model
(
   input  wire logic sys_clk,         // system clock
   output var logic  ext_pin,         // pulled up when idle
   output var logic  other_timer_ovf  // one-cycle pulse
);
   initial ext_pin = 1'b1;
   initial other_timer_ovf = 1'b0;
   task automatic fall_edge();
      ext_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ext_pin <= 1'b1;
      @(posedge sys_clk);
   endtask : fall_edge
   task automatic ovf_pulse();
      other_timer_ovf <= 1'b1;
      @(posedge sys_clk);
      other_timer_ovf <= 1'b0;
   endtask : ovf_pulse
endmodule : timer_pins_model
`default_nettype wire

// [dv/test_sys_timers.sv]
// self-checking bench for sys_timers over apb
// assumes the pin model beside it and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module test_sys_timers;
   import sys_timers_pkg::*;
   logic        sys_clk, rstn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, rx_clk, tx_clk, rt_irq, s1_irq, s2_irq;
   wire logic   ext_pin, other_timer_ovf;
   int          n_fail, n_checks;
   sys_timers dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
      .serial_rx_clk(rx_clk), .serial_tx_clk(tx_clk),
      .other_timer_ovf(other_timer_ovf), .reload_timer_irq(rt_irq),
      .first_simple_irq(s1_irq), .second_simple_irq(s2_irq));
   timer_pins_model pins (.sys_clk(sys_clk), .ext_pin(ext_pin),
      .other_timer_ovf(other_timer_ovf));
   initial
   begin
      {sys_clk, rstn, psel, penable, pwrite, n_fail, n_checks} = '0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   always #20 sys_clk = ~sys_clk;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd,
                      output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] rd;
      logic       er;
      bus(1'b1, idx, d, rd, er);
   endtask : wr
   task automatic rdchk(input string nm, input logic [7:0] idx,
                        input logic [7:0] e);
      logic [7:0] rd;
      logic       er;
      bus(1'b0, idx, 8'h00, rd, er);
      `CHK(nm, {1'b0, e}, {er, rd})
   endtask : rdchk
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      complete_run();
   end
   initial
   begin
      logic [7:0] rd, lo, hi;
      logic       er;
      int         sh;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk("ctrl reset", ADDR_ST_CTRL, CTRL_RESET);
      rdchk("count reset", ADDR_S1_LOW, COUNT_RESET[7:0]);
      bus(1'b0, 8'h00, 8'h00, rd, er);
      `CHK("unmapped", 1'b1, er)
      $display("test registers done");
      for (int t = 0; t < 2; t++)
      begin
         lo = t ? ADDR_S2_LOW : ADDR_S1_LOW;
         hi = t ? ADDR_S2_HIGH : ADDR_S1_HIGH;
         sh = t * 4;
         wr(hi, 8'hFF);
         wr(lo, 8'hF0);
         rdchk("held count", lo, 8'hF0);
         wr(ADDR_ST_CTRL, 8'h04 << sh);
         wr(hi, 8'h12);
         wr(lo, 8'h34);
         rdchk("live count", lo, 8'hF0);
         wr(ADDR_ST_CTRL, 8'h07 << sh);
         repeat (30) @(posedge sys_clk);
         rdchk("reloaded", hi, 8'h12);
         rdchk("flag set", ADDR_ST_CTRL, 8'h0F << sh);
         `CHK("irq on", 2'b01 << t, {s2_irq, s1_irq})
         wr(ADDR_ST_CTRL, 8'h09 << sh);
         wr(ADDR_ST_CTRL, 8'h00);
         rdchk("flag clear", ADDR_ST_CTRL, 8'h00);
      end
      $display("test simple timers done");
      wr(ADDR_RC_HIGH, 8'hAB);
      wr(ADDR_RC_LOW, 8'hCD);
      wr(ADDR_RT_HIGH, 8'hFF);
      wr(ADDR_RT_LOW, 8'hF0);
      wr(ADDR_RT_CTRL, 8'h04);
      repeat (30) @(posedge sys_clk);
      rdchk("rt reload", ADDR_RT_HIGH, 8'hAB);
      rdchk("rt flag", ADDR_RT_CTRL, 8'h84);
      `CHK("rt irq", 1'b1, rt_irq)
      wr(ADDR_RT_CTRL, 8'h09);
      wr(ADDR_RT_HIGH, 8'h55);
      wr(ADDR_RT_LOW, 8'h00);
      wr(ADDR_RT_CTRL, 8'h0D);
      pins.fall_edge();
      rdchk("captured", ADDR_RC_HIGH, 8'h55);
      rdchk("edge flag", ADDR_RT_CTRL, 8'h4D);
      `CHK("edge irq", 1'b1, rt_irq)
      wr(ADDR_RT_CTRL, 8'h08);
      wr(ADDR_RT_HIGH, 8'h10);
      wr(ADDR_RT_CTRL, 8'h0C);
      pins.fall_edge();
      rdchk("trig reload", ADDR_RT_HIGH, 8'h55);
      $display("test reload timer done");
      wr(ADDR_RT_CTRL, 8'h00);
      wr(ADDR_RC_HIGH, 8'hFF);
      wr(ADDR_RC_LOW, 8'hF0);
      wr(ADDR_RT_HIGH, 8'hFF);
      wr(ADDR_RT_LOW, 8'hF0);
      wr(ADDR_RT_CTRL, 8'h35);
      for (int n = 0; n < 40 && rx_clk !== 1'b1; n++)
         @(posedge sys_clk);
      `CHK("rx baud", 1'b1, rx_clk)
      `CHK("tx baud", 1'b1, tx_clk)
      repeat (20) @(posedge sys_clk);
      rdchk("baud reload", ADDR_RT_HIGH, 8'hFF);
      rdchk("no flag", ADDR_RT_CTRL, 8'h35);
      wr(ADDR_RT_CTRL, 8'h00);
      pins.ovf_pulse();
      @(posedge sys_clk);
      `CHK("other ovf", 1'b1, tx_clk)
      `CHK("other ovf rx", 1'b1, rx_clk)
      $display("test baud done");
      wr(ADDR_RT_HIGH, 8'hFF);
      wr(ADDR_RT_LOW, 8'hFF);
      wr(ADDR_RT_CTRL, 8'h07);
      repeat (10) @(posedge sys_clk);
      rdchk("pin count idle", ADDR_RT_LOW, 8'hFF);
      pins.fall_edge();
      rdchk("capture wrap", ADDR_RT_HIGH, 8'h00);
      rdchk("capture flag", ADDR_RT_CTRL, 8'h87);
      $display("test pin count done");
      complete_run();
   end
endmodule : test_sys_timers
`default_nettype wire
